// [rtl/sar_cfg.svh]
// Operation
// - Host rising edge on conversion start ends acquisition and begins conversion.
// - Open both comparator-node ground switches first, then move arrays to ground.
// - Convert the input held at the end of acquisition, never a later value.
// - Sixteen binary-weighted elements per side give a 16-bit result.
// - Trials run from MSB to LSB, each half the previous weight.
// - After the last trial: back to acquisition, form code, signal busy end.
// - Conversion timed by an internal clock, no serial clock needed.
// - All options set through one 14-bit configuration register over the serial port.
// - Results readable after conversion only, always with the configuration appended.
// - Each result belongs to the latest conversion, no pipeline latency.
// - Start pin held low during conversion enables busy on the serial output.
// - Configuration writes accepted both during and after a conversion.
// - Serial clock shifts results out and configuration in, MSB first.
// - Straight binary in unipolar modes, twos complement in bipolar modes.
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH
`define SAR_RES_BITS     16
`define SAR_CFG_BITS     14
`define SAR_CONV_DIV     4
`define SAR_CFG_RESET    14'h3fff
`define SAR_CFG_MODE_HI  12
`define SAR_CFG_MODE_LO  10
`define SAR_CFG_RB_BIT   0
`define SAR_MODE_BIPOLAR 3'h2
`define SAR_MAX_KSPS     250
`endif

// [rtl/sar_conversion_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sar_cfg.svh"
module sar_conversion_sequencer #(
  parameter int RES_BITS = `SAR_RES_BITS,
  parameter int CFG_BITS = `SAR_CFG_BITS,
  parameter int CONV_DIV = `SAR_CONV_DIV
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // Host pins
  input  wire logic                conv_start_pin,
  input  wire logic                sck,
  input  wire logic                din,
  output logic                     serial_result_out,
  output logic                     serial_result_oe,
  // Analog array control
  output logic                     pos_node_ground_switch,
  output logic                     neg_node_ground_switch,
  output logic                     array_to_inputs,
  output logic [RES_BITS-1:0]      dac_trial,
  input  wire logic                comparator_high,
  // Status
  output logic                     conv_busy,
  output logic [CFG_BITS-1:0]      active_cfg
);

  localparam int SH_BITS = RES_BITS + CFG_BITS;
  localparam int BW      = $clog2(SH_BITS + 1);

  // Comparator is resampled through two flops, so a tick must outlast that delay
  // The tick divider is eight bits wide, which caps the divide ratio at 256
  if (CONV_DIV < 4 || CONV_DIV > 256 ||
      RES_BITS != `SAR_RES_BITS || CFG_BITS != `SAR_CFG_BITS) begin : g_bad_params
    $error("sar_conversion_sequencer: unsupported parameters");
  end

  function automatic logic [RES_BITS-1:0] code_format(input logic [RES_BITS-1:0] raw,
                                                      input logic [CFG_BITS-1:0] cfg);
    code_format = raw;
    if (cfg[`SAR_CFG_MODE_HI:`SAR_CFG_MODE_LO] == `SAR_MODE_BIPOLAR)
      code_format[RES_BITS-1] = ~raw[RES_BITS-1];
  endfunction : code_format

  // Input synchronisers
  // Edge detectors reset to the idle-low pin level, so reset release shows no false edge
  logic [1:0] start_s_q, sck_s_q, din_s_q, cmp_s_q;
  logic       start_p_q, sck_p_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      start_s_q <= 2'h0;
      sck_s_q   <= 2'h0;
      din_s_q   <= 2'h0;
      cmp_s_q   <= 2'h0;
      start_p_q <= 1'b0;
      sck_p_q   <= 1'b0;
    end else begin
      start_s_q <= {start_s_q[0], conv_start_pin};
      sck_s_q   <= {sck_s_q[0], sck};
      din_s_q   <= {din_s_q[0], din};
      cmp_s_q   <= {cmp_s_q[0], comparator_high};
      start_p_q <= start_s_q[1];
      sck_p_q   <= sck_s_q[1];
    end
  end

  logic start_lvl, start_rise, sck_rise, sck_fall, din_v, cmp_v;
  assign start_lvl  = start_s_q[1];
  assign start_rise = start_lvl & ~start_p_q;
  assign sck_rise   = sck_s_q[1] & ~sck_p_q;
  assign sck_fall   = ~sck_s_q[1] & sck_p_q;
  assign din_v      = din_s_q[1];
  assign cmp_v      = cmp_s_q[1];

  // Sequencer state
  sar_pkg::sar_state_t  st_q, st_d;
  logic [7:0]           div_q, div_d;
  logic [RES_BITS-1:0]  bit_q, bit_d;
  logic [RES_BITS-1:0]  trial_q, trial_d;
  logic                 tick;

  // Serial state
  logic [SH_BITS-1:0]   sh_q, sh_d;
  logic [CFG_BITS-1:0]  cin_q, cin_d;
  logic [BW-1:0]        cin_cnt_q, cin_cnt_d;
  logic [CFG_BITS-1:0]  pend_q, pend_d;
  logic                 pend_v_q, pend_v_d;
  logic [CFG_BITS-1:0]  cfg_q, cfg_d;
  logic [CFG_BITS-1:0]  used_q, used_d;
  logic                 pend_set;

  assign pend_set = !start_lvl && sck_rise && cin_cnt_q == BW'(CFG_BITS - 1);

  assign tick = (div_q == 8'(CONV_DIV - 1));

  always_comb begin
    st_d    = st_q;
    // Divider idles at zero in acquisition, so every conversion has the same length
    div_d   = (st_q == sar_pkg::SAR_ACQ || tick) ? 8'h00 : div_q + 8'h01;
    bit_d   = bit_q;
    trial_d = trial_q;
    used_d  = used_q;
    cfg_d   = cfg_q;
    pend_v_d = pend_v_q;
    sh_d    = sh_q;
    unique case (st_q)
      sar_pkg::SAR_ACQ: begin
        if (start_rise) begin
          st_d    = sar_pkg::SAR_FLOAT;
          trial_d = '0;
          if (pend_v_q) begin
            cfg_d    = pend_q;
            used_d   = pend_q;
            pend_v_d = 1'b0;
          end else begin
            used_d = cfg_q;
          end
        end
      end
      sar_pkg::SAR_FLOAT: begin
        if (tick)
          st_d = sar_pkg::SAR_HOLD;
      end
      sar_pkg::SAR_HOLD: begin
        // Arrays now hold the sample; trials open at mid-scale
        if (tick) begin
          st_d    = sar_pkg::SAR_TRIAL;
          bit_d   = {1'b1, {(RES_BITS-1){1'b0}}};
          trial_d = {1'b1, {(RES_BITS-1){1'b0}}};
        end
      end
      sar_pkg::SAR_TRIAL: begin
        if (tick) begin
          // Keep the bit if the held sample is still at or above the trial level
          trial_d = cmp_v ? trial_q : (trial_q & ~bit_q);
          if (bit_q[0]) begin
            st_d = sar_pkg::SAR_ACQ;
            // Result replaces the shifter right away, so no stale code is read
            sh_d = {code_format(cmp_v ? trial_q : (trial_q & ~bit_q), used_q),
                    used_q};
          end else begin
            bit_d   = bit_q >> 1;
            trial_d = (cmp_v ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
          end
        end
      end
    endcase
    // A shift edge landing on the result load is dropped, so the fresh result keeps its MSB
    if (sck_fall && !start_lvl && !(st_q == sar_pkg::SAR_TRIAL && st_d == sar_pkg::SAR_ACQ))
      sh_d = {sh_q[SH_BITS-2:0], 1'b0};
    // A completed word is flagged last, so it wins over any consume in the same cycle
    if (pend_set)
      pend_v_d = 1'b1;
  end

  // Configuration intake runs independently of the converter state
  // A partial word is dropped when the pin rises, since the bit count restarts
  always_comb begin
    cin_d     = cin_q;
    cin_cnt_d = cin_cnt_q;
    pend_d    = pend_q;
    if (start_lvl) begin
      cin_cnt_d = '0;
    end else if (sck_rise && cin_cnt_q < BW'(CFG_BITS)) begin
      cin_d     = {cin_q[CFG_BITS-2:0], din_v};
      cin_cnt_d = cin_cnt_q + BW'(1);
      if (cin_cnt_q == BW'(CFG_BITS - 1))
        pend_d = {cin_q[CFG_BITS-2:0], din_v};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= sar_pkg::SAR_ACQ;
      div_q     <= 8'h00;
      bit_q     <= '0;
      trial_q   <= '0;
      sh_q      <= '0;
      cin_q     <= '0;
      cin_cnt_q <= '0;
      pend_q    <= `SAR_CFG_RESET;
      pend_v_q  <= 1'b0;
      cfg_q     <= `SAR_CFG_RESET;
      used_q    <= `SAR_CFG_RESET;
    end else begin
      st_q      <= st_d;
      div_q     <= div_d;
      bit_q     <= bit_d;
      trial_q   <= trial_d;
      sh_q      <= sh_d;
      cin_q     <= cin_d;
      cin_cnt_q <= cin_cnt_d;
      pend_q    <= pend_d;
      pend_v_q  <= pend_v_d;
      cfg_q     <= cfg_d;
      used_q    <= used_d;
    end
  end

  // The configuration word always trails the result
  // A host that wants only the code stops after sixteen clocks and loses nothing
  logic shift_msb;
  assign shift_msb = sh_q[SH_BITS-1];

  always_comb begin
    conv_busy              = (st_q != sar_pkg::SAR_ACQ);
    pos_node_ground_switch = (st_q == sar_pkg::SAR_ACQ);
    neg_node_ground_switch = (st_q == sar_pkg::SAR_ACQ);
    array_to_inputs        = (st_q == sar_pkg::SAR_ACQ || st_q == sar_pkg::SAR_FLOAT);
    dac_trial              = trial_q;
    active_cfg             = cfg_q;
    serial_result_oe       = !start_lvl;
    if (start_lvl)
      serial_result_out = 1'b0;
    else if (conv_busy)
      serial_result_out = 1'b1;
    else
      serial_result_out = shift_msb;
  end

endmodule : sar_conversion_sequencer
`default_nettype wire

// [rtl/sar_pkg.sv]
package sar_pkg;
  typedef enum logic [1:0] {
    SAR_ACQ     = 2'b00,
    SAR_FLOAT   = 2'b01,
    SAR_HOLD    = 2'b10,
    SAR_TRIAL   = 2'b11
  } sar_state_t;
endpackage : sar_pkg

// [verification/sar_cmp_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_cmp_model (
  input  wire logic        core_clk,
  input  wire logic        array_to_inputs,
  input  wire logic [15:0] dac_trial,
  input  wire logic [15:0] vin,
  output logic             comparator_high
);
  logic [15:0] held_q;
  // Tracks only while the arrays sit on the inputs, so a late input change cannot leak in
  always_ff @(posedge core_clk) if (array_to_inputs) held_q <= vin;
  assign comparator_high = (dac_trial <= held_q);
endmodule : sar_cmp_model
`default_nettype wire

// [verification/sar_conversion_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_conversion_sequencer_test;
  logic        core_clk, resetn, conv_start_pin, sck, din;
  logic        res_out, oe, gnd_p, gnd_n, arr, cmp, busy;
  logic [15:0] dac, vin;
  logic [13:0] cfg;
  logic [29:0] rd;
  int          errors, cmp_count, cyc;
  sar_conversion_sequencer dut (.core_clk(core_clk), .resetn(resetn), .conv_start_pin(conv_start_pin),
    .sck(sck), .din(din), .serial_result_out(res_out), .serial_result_oe(oe), .pos_node_ground_switch(gnd_p),
    .neg_node_ground_switch(gnd_n), .array_to_inputs(arr), .dac_trial(dac), .comparator_high(cmp),
    .conv_busy(busy), .active_cfg(cfg));
  sar_cmp_model u_cmp (.core_clk(core_clk), .array_to_inputs(arr), .dac_trial(dac), .vin(vin),
    .comparator_high(cmp));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      print_verdict();
    end
  end
  task automatic chk(input logic [29:0] got, input logic [29:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Host frame: config in and result out, 160 ns serial clock; ending it raises the start pin
  task automatic frame(input logic [13:0] w);
    conv_start_pin = 0;
    for (int i = 29; i >= 0; i--) begin
      din = (i > 15) ? w[i-16] : 1'b0;
      repeat (8) @(negedge core_clk);
      rd[i] = res_out;
      sck = 1;
      repeat (8) @(negedge core_clk);
      sck = 0;
    end
    // Conversion plus frame span about 600 cycles, well over the 400-cycle start spacing
    repeat (8) @(negedge core_clk);
    conv_start_pin = 1;
  endtask : frame
  // Serial clock stays idle throughout, input moves after the hold
  task automatic wait_done();
    repeat (10) @(negedge core_clk);
    chk({busy, gnd_p, gnd_n, arr, oe, res_out}, 6'b100000);
    vin = ~vin;
    repeat (100) @(negedge core_clk);
    chk({busy, gnd_p, gnd_n, arr, dac}, {4'b0111, ~vin});
  endtask : wait_done
  task automatic test_unipolar();
    chk(cfg, 14'h3fff);
    conv_start_pin = 1;
    wait_done();
    frame(14'h0900);
    chk(rd, {16'h5a3c, 14'h3fff});
    $display("test unipolar done");
  endtask : test_unipolar
  task automatic test_bipolar();
    wait_done();
    chk(cfg, 14'h0900);
    frame(14'h3fff);
    chk(rd, {16'h25c3, 14'h0900});
    $display("test bipolar done");
  endtask : test_bipolar
  task automatic test_busy_flag();
    repeat (10) @(negedge core_clk);
    conv_start_pin = 0;
    repeat (6) @(negedge core_clk);
    chk({res_out, oe}, 2'b11);
    repeat (100) @(negedge core_clk);
    chk({busy, res_out}, 2'b00);
    $display("test busy flag done");
  endtask : test_busy_flag
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    {resetn, conv_start_pin, sck, din} = 4'h0;
    vin = 16'h5a3c;
    repeat (4) @(negedge core_clk);
    resetn = 1;
    repeat (4) @(negedge core_clk);
    test_unipolar();
    test_bipolar();
    test_busy_flag();
    print_verdict();
  end
endmodule : sar_conversion_sequencer_test
`default_nettype wire

// [verification/sar_seq_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module sar_seq_asserts #(
  parameter int RES_BITS = 16,
  parameter int CFG_BITS = 14
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                resetn,
  // Host pins
  input  wire logic                conv_start_pin,
  input  wire logic                serial_result_out,
  input  wire logic                serial_result_oe,
  // Array and status
  input  wire logic                pos_node_ground_switch,
  input  wire logic                neg_node_ground_switch,
  input  wire logic                array_to_inputs,
  input  wire logic [RES_BITS-1:0] dac_trial,
  input  wire logic                conv_busy,
  input  wire logic [CFG_BITS-1:0] active_cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_start; $rose(conv_start_pin) && !conv_busy |-> ##[2:5] conv_busy; endproperty
  property p_gnd_first; $fell(pos_node_ground_switch) |-> array_to_inputs && !neg_node_ground_switch; endproperty
  property p_arr_gnd; $fell(array_to_inputs) |-> !pos_node_ground_switch && !neg_node_ground_switch; endproperty
  // Fixed length only holds for the default divider of 4
  property p_len; $rose(conv_busy) |-> ##71 conv_busy ##1 !conv_busy; endproperty
  property p_msb; $rose(conv_busy) |-> ##[1:12] (dac_trial == 16'h8000); endproperty
  property p_idle; !conv_busy |-> pos_node_ground_switch && neg_node_ground_switch && array_to_inputs; endproperty
  property p_busy_out; (conv_busy && !conv_start_pin)[*4] |-> serial_result_out; endproperty
  property p_quiet; conv_start_pin[*4] |-> !serial_result_oe && !serial_result_out; endproperty
  property p_cfg; conv_busy && $past(conv_busy) |-> $stable(active_cfg); endproperty
  a_start: assert property (p_start) else $error("start edge ignored");
  a_gnd_first: assert property (p_gnd_first) else $error("switches not opened first");
  a_arr_gnd: assert property (p_arr_gnd) else $error("arrays left inputs with switches closed");
  a_len: assert property (p_len) else $error("conversion length wrong");
  a_msb: assert property (p_msb) else $error("first trial not MSB");
  a_idle: assert property (p_idle) else $error("not back in acquisition");
  a_busy_out: assert property (p_busy_out) else $error("busy not on serial out");
  a_quiet: assert property (p_quiet) else $error("serial out driven with pin high");
  a_cfg: assert property (p_cfg) else $error("config changed mid conversion");
  c_rise: cover property ($rose(conv_busy));
  c_fall: cover property ($fell(conv_busy));
  c_busy_low: cover property (conv_busy && !conv_start_pin);
endmodule : sar_seq_asserts
bind sar_conversion_sequencer sar_seq_asserts #(.RES_BITS(RES_BITS), .CFG_BITS(CFG_BITS)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .conv_start_pin(conv_start_pin),
  .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
  .pos_node_ground_switch(pos_node_ground_switch), .neg_node_ground_switch(neg_node_ground_switch),
  .array_to_inputs(array_to_inputs), .dac_trial(dac_trial), .conv_busy(conv_busy), .active_cfg(active_cfg));
`default_nettype wire
